// ### hw/pwm_defines.svh
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// register byte offsets
`define PWM_ADDR_W        5
`define PWM_REG_CTRL      5'h00
`define PWM_REG_CMP_A     5'h04
`define PWM_REG_CMP_B     5'h08
`define PWM_REG_COUNT     5'h0C
`define PWM_REG_PRESC     5'h10
`define PWM_REG_STATUS    5'h14

// control register fields
`define PWM_CTRL_WGM_LSB  0
`define PWM_CTRL_WGM_MSB  2
`define PWM_CTRL_ACTA_LSB 4
`define PWM_CTRL_ACTA_MSB 5
`define PWM_CTRL_ACTB_LSB 6
`define PWM_CTRL_ACTB_MSB 7

// status register fields
`define PWM_STAT_OVF_BIT  0
`define PWM_STAT_DIR_BIT  1

// counter limits and reset values
`define PWM_BOTTOM        8'h00
`define PWM_FIXED_TOP     8'hFF
`define PWM_RST_CTRL      8'h00
`define PWM_RST_CMP       8'h00
`define PWM_RST_COUNT     8'h00
`define PWM_RST_PRESC     8'h00

`endif

// ### hw/pwm_pkg.sv
`default_nettype none

package pwm_pkg;

    typedef enum logic [2:0] {
        WGM_NORMAL   = 3'b000,
        WGM_PC_FIXED = 3'b001,
        WGM_PC_CMPA  = 3'b101
    } waveform_e;

    typedef enum logic [1:0] {
        ACT_OFF    = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLR_UP = 2'b10,
        ACT_SET_UP = 2'b11
    } action_e;

    typedef enum logic {
        DIR_DOWN = 1'b0,
        DIR_UP   = 1'b1
    } dir_e;

    function automatic logic is_pwm_mode(input logic [2:0] wgm);
        return (wgm == WGM_PC_FIXED) || (wgm == WGM_PC_CMPA);
    endfunction

endpackage

`default_nettype wire

// ### hw/pwm_cmp_if.sv
`default_nettype none

interface pwm_cmp_if #(
    parameter int W = 8
);
    logic         tick;
    logic         pwm_on;
    logic         dir_up;
    logic [W-1:0] count;
    logic [W-1:0] cmp_value;
    logic [1:0]   action;
    logic         pin;

    modport timer (
        output tick,
        output pwm_on,
        output dir_up,
        output count,
        output cmp_value,
        output action,
        input  pin
    );

    modport chan (
        input  tick,
        input  pwm_on,
        input  dir_up,
        input  count,
        input  cmp_value,
        input  action,
        output pin
    );
endinterface

`default_nettype wire

// ### hw/pwm_cmp_chan.sv
`default_nettype none

module pwm_cmp_chan
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // counter side
    pwm_cmp_if.chan  cmp
);

    logic state_ff;
    logic nxt_state;
    logic pin_ff;
    logic nxt_pin;
    logic match;

    assign match = cmp.tick && cmp.pwm_on && (cmp.count == cmp.cmp_value);

    always_comb begin
        nxt_state = state_ff;
        if (match) begin
            case (cmp.action)
                ACT_CLR_UP: nxt_state = ~cmp.dir_up;
                ACT_SET_UP: nxt_state = cmp.dir_up;
                default:    nxt_state = state_ff;
            endcase
        end
        // pin is only driven by the compare unit for the two pwm actions
        nxt_pin = cmp.action[1] ? nxt_state : 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff <= 1'b0;
            pin_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pin_ff   <= nxt_pin;
        end
    end

    assign cmp.pin = pin_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_match_up;
        match && cmp.dir_up;
    endsequence

    sequence s_match_down;
        match && !cmp.dir_up;
    endsequence

    property p_noninv_up;
        (cmp.action == ACT_CLR_UP) and s_match_up |=> !pin_ff;
    endproperty
    a_noninv_up: assert property (p_noninv_up)
        else $error("non-inverting match while counting up did not clear");

    property p_noninv_down;
        (cmp.action == ACT_CLR_UP) and s_match_down |=> pin_ff;
    endproperty
    a_noninv_down: assert property (p_noninv_down)
        else $error("non-inverting match while counting down did not set");

    property p_inv_both;
        (cmp.action == ACT_SET_UP) && match |=> pin_ff == $past(cmp.dir_up);
    endproperty
    a_inv_both: assert property (p_inv_both)
        else $error("inverting match gave the wrong output level");

    property p_off_low;
        !cmp.action[1] |=> !pin_ff;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("output driven while no pwm action selected");

endmodule

`default_nettype wire

// ### hw/pwm_timer.sv
// What this block does
// - Waveform select 1 or 5 gives phase-correct pwm
// - Counter climbs to TOP then descends to BOTTOM
// - Mode 1 TOP 0xFF; mode 5 compare A
// - Non-inverting: clear on up match, set on down
// - Inverting: set on up match, clear on down
// - Action two is non-inverting, three is inverting
// - Direction turns at TOP, TOP lasts one tick
// - Overflow flag set each time BOTTOM is reached
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`include "pwm_defines.svh"
`default_nettype none

module pwm_timer
    import pwm_pkg::*;
(
    // clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_N,
    // avalon-mm slave
    input  wire logic [4:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output var  logic [31:0] O_AVS_READDATA,
    output var  logic        O_AVS_WAITREQUEST,
    // waveform pins and status
    output var  logic        O_COMPARE_OUTPUT_A,
    output var  logic        O_COMPARE_OUTPUT_B,
    output var  logic        O_OVERFLOW_FLAG,
    output var  logic [7:0]  O_COUNTER_VALUE
);

    // bus slave state
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        wr_go;

    // software registers
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  cmp_a_ff;
    logic [7:0]  nxt_cmp_a;
    logic [7:0]  cmp_b_ff;
    logic [7:0]  nxt_cmp_b;
    logic [7:0]  presc_ff;
    logic [7:0]  nxt_presc;

    // timer state
    logic [7:0]  div_ff;
    logic [7:0]  nxt_div;
    logic [7:0]  cnt_ff;
    logic [7:0]  nxt_cnt;
    dir_e        dir_ff;
    dir_e        nxt_dir;
    logic        ovf_ff;
    logic        nxt_ovf;
    logic [7:0]  act_a_ff;
    logic [7:0]  nxt_act_a;
    logic [7:0]  act_b_ff;
    logic [7:0]  nxt_act_b;

    logic [2:0]  wgm;
    logic        pwm_on;
    logic        tick;
    logic [7:0]  top;
    logic        cnt_wr;
    logic        at_top;
    logic        step;
    logic        ovf_set;
    logic        ovf_clr;

    pwm_cmp_if #(.W(8)) chan_a_if ();
    pwm_cmp_if #(.W(8)) chan_b_if ();

    // one wait cycle on every access keeps read data registered
    assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !ack_ff;
    assign wr_go = I_AVS_WRITE && ack_ff && I_AVS_BYTEENABLE[0];

    assign wgm    = ctrl_ff[`PWM_CTRL_WGM_MSB:`PWM_CTRL_WGM_LSB];
    assign pwm_on = is_pwm_mode(wgm);
    assign top    = (wgm == WGM_PC_CMPA) ? act_a_ff
                                         : `PWM_FIXED_TOP;
    assign tick   = (div_ff == presc_ff);
    assign cnt_wr = wr_go && (I_AVS_ADDRESS == `PWM_REG_COUNT);
    // a software counter write takes the cycle; no step, no match
    assign step   = tick && pwm_on && !cnt_wr;
    assign at_top = (dir_ff == DIR_UP) && (cnt_ff >= top);
    assign ovf_set = step && (cnt_ff == `PWM_BOTTOM);
    assign ovf_clr = wr_go && (I_AVS_ADDRESS == `PWM_REG_STATUS)
                     && I_AVS_WRITEDATA[`PWM_STAT_OVF_BIT];

    always_comb begin
        nxt_ack   = (I_AVS_READ || I_AVS_WRITE) && !ack_ff;
        nxt_rdata = rdata_ff;
        if (I_AVS_READ && !ack_ff) begin
            nxt_rdata = 32'h0000_0000;
            case (I_AVS_ADDRESS)
                `PWM_REG_CTRL:   nxt_rdata[7:0] = ctrl_ff;
                `PWM_REG_CMP_A:  nxt_rdata[7:0] = cmp_a_ff;
                `PWM_REG_CMP_B:  nxt_rdata[7:0] = cmp_b_ff;
                `PWM_REG_COUNT:  nxt_rdata[7:0] = cnt_ff;
                `PWM_REG_PRESC:  nxt_rdata[7:0] = presc_ff;
                `PWM_REG_STATUS: begin
                    nxt_rdata[`PWM_STAT_OVF_BIT] = ovf_ff;
                    nxt_rdata[`PWM_STAT_DIR_BIT] = dir_ff;
                end
                default:         nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_cmp_a = cmp_a_ff;
        nxt_cmp_b = cmp_b_ff;
        nxt_presc = presc_ff;
        if (wr_go) begin
            case (I_AVS_ADDRESS)
                `PWM_REG_CTRL:  nxt_ctrl  = I_AVS_WRITEDATA[7:0];
                `PWM_REG_CMP_A: nxt_cmp_a = I_AVS_WRITEDATA[7:0];
                `PWM_REG_CMP_B: nxt_cmp_b = I_AVS_WRITEDATA[7:0];
                `PWM_REG_PRESC: nxt_presc = I_AVS_WRITEDATA[7:0];
                default:        nxt_ctrl  = ctrl_ff;
            endcase
        end
    end

    always_comb begin
        nxt_div = tick ? 8'h00 : div_ff + 8'h01;
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        if (!pwm_on) begin
            nxt_dir = DIR_UP;
        end
        if (cnt_wr) begin
            nxt_cnt = I_AVS_WRITEDATA[7:0];
        end else if (step) begin
            if (dir_ff == DIR_UP) begin
                if (at_top) begin
                    // the count showed TOP for exactly this tick
                    nxt_dir = DIR_DOWN;
                    nxt_cnt = (cnt_ff == `PWM_BOTTOM) ? `PWM_BOTTOM
                                                      : cnt_ff - 8'h01;
                end else begin
                    nxt_cnt = cnt_ff + 8'h01;
                end
            end else begin
                if (cnt_ff == `PWM_BOTTOM) begin
                    nxt_dir = DIR_UP;
                    nxt_cnt = (top == `PWM_BOTTOM) ? `PWM_BOTTOM
                                                   : cnt_ff + 8'h01;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
        end
    end

    always_comb begin
        // set wins over a clear in the same cycle
        nxt_ovf = ovf_set || (ovf_ff && !ovf_clr);
        // compare values are double buffered and taken over at TOP so a
        // period never sees two different thresholds
        nxt_act_a = act_a_ff;
        nxt_act_b = act_b_ff;
        if (!pwm_on || (step && at_top)) begin
            nxt_act_a = cmp_a_ff;
            nxt_act_b = cmp_b_ff;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff  <= `PWM_RST_CTRL;
            cmp_a_ff <= `PWM_RST_CMP;
            cmp_b_ff <= `PWM_RST_CMP;
            presc_ff <= `PWM_RST_PRESC;
            div_ff   <= 8'h00;
            cnt_ff   <= `PWM_RST_COUNT;
            dir_ff   <= DIR_UP;
            ovf_ff   <= 1'b0;
            act_a_ff <= `PWM_RST_CMP;
            act_b_ff <= `PWM_RST_CMP;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
            ctrl_ff  <= nxt_ctrl;
            cmp_a_ff <= nxt_cmp_a;
            cmp_b_ff <= nxt_cmp_b;
            presc_ff <= nxt_presc;
            div_ff   <= nxt_div;
            cnt_ff   <= nxt_cnt;
            dir_ff   <= nxt_dir;
            ovf_ff   <= nxt_ovf;
            act_a_ff <= nxt_act_a;
            act_b_ff <= nxt_act_b;
        end
    end

    assign chan_a_if.tick      = step;
    assign chan_a_if.pwm_on    = pwm_on;
    assign chan_a_if.dir_up    = (dir_ff == DIR_UP);
    assign chan_a_if.count     = cnt_ff;
    assign chan_a_if.cmp_value = act_a_ff;
    assign chan_a_if.action    =
        ctrl_ff[`PWM_CTRL_ACTA_MSB:`PWM_CTRL_ACTA_LSB];

    assign chan_b_if.tick      = step;
    assign chan_b_if.pwm_on    = pwm_on;
    assign chan_b_if.dir_up    = (dir_ff == DIR_UP);
    assign chan_b_if.count     = cnt_ff;
    assign chan_b_if.cmp_value = act_b_ff;
    assign chan_b_if.action    =
        ctrl_ff[`PWM_CTRL_ACTB_MSB:`PWM_CTRL_ACTB_LSB];

    pwm_cmp_chan u_chan_a (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .cmp     (chan_a_if.chan)
    );

    pwm_cmp_chan u_chan_b (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .cmp     (chan_b_if.chan)
    );

    assign O_AVS_READDATA     = rdata_ff;
    assign O_COMPARE_OUTPUT_A = chan_a_if.pin;
    assign O_COMPARE_OUTPUT_B = chan_b_if.pin;
    assign O_OVERFLOW_FLAG    = ovf_ff;
    assign O_COUNTER_VALUE    = cnt_ff;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_reach_top;
        step && at_top && (cnt_ff != `PWM_BOTTOM);
    endsequence

    sequence s_turn_down;
        (dir_ff == DIR_DOWN) && (cnt_ff == $past(cnt_ff) - 8'h01);
    endsequence

    property p_mode_gate;
        !pwm_on && !cnt_wr |=> $stable(cnt_ff);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("counter moved outside phase-correct mode");

    property p_climb;
        step && (dir_ff == DIR_UP) && !at_top
            |=> cnt_ff == $past(cnt_ff) + 8'h01;
    endproperty
    a_climb: assert property (p_climb)
        else $error("counter did not climb by one below TOP");

    property p_rise_at_bottom;
        step && (dir_ff == DIR_DOWN) && (cnt_ff == `PWM_BOTTOM)
            |=> dir_ff == DIR_UP;
    endproperty
    a_rise_at_bottom: assert property (p_rise_at_bottom)
        else $error("direction did not turn up at BOTTOM");

    property p_fixed_top;
        step && (wgm == WGM_PC_FIXED) && (dir_ff == DIR_UP)
            && (cnt_ff == 8'hFE) |=> cnt_ff == 8'hFF && dir_ff == DIR_UP;
    endproperty
    a_fixed_top: assert property (p_fixed_top)
        else $error("fixed TOP mode did not reach 0xFF");

    property p_cmpa_top;
        step && (wgm == WGM_PC_CMPA) && (dir_ff == DIR_UP)
            && (cnt_ff == act_a_ff) && (cnt_ff != `PWM_BOTTOM)
            |=> dir_ff == DIR_DOWN;
    endproperty
    a_cmpa_top: assert property (p_cmpa_top)
        else $error("compare A did not act as TOP");

    property p_top_turn;
        s_reach_top |=> s_turn_down;
    endproperty
    a_top_turn: assert property (p_top_turn)
        else $error("counter did not turn down after one tick at TOP");

    property p_ovf_set;
        ovf_set |=> ovf_ff;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set at BOTTOM");

    property p_hold_between_ticks;
        !tick && !cnt_wr |=> $stable(cnt_ff) [*1];
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks)
        else $error("counter moved without a timer tick");

endmodule

`default_nettype wire

// ### verification/phase_correct_pwm_timer_bench.sv
`include "pwm_defines.svh"
`default_nettype none

module phase_correct_pwm_timer_bench
    import pwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst_n;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  ben;
    logic [31:0] rdata;
    logic        waitreq;
    logic        pin_a;
    logic        pin_b;
    logic        ovf;
    logic [7:0]  cnt;
    int          err_count;
    int          n_checks;
    bit          m_on;
    logic [7:0]  m_ctrl, m_ca, m_cb, m_aa, m_ab, m_cnt;
    logic        m_up, m_ovf, m_set, m_pa, m_pb;
    bit          m_ka, m_kb;

    pwm_timer i_dut (
        .I_CORE_CLK         (clk),
        .I_RST_N            (rst_n),
        .I_AVS_ADDRESS      (addr),
        .I_AVS_READ         (rd),
        .I_AVS_WRITE        (wr),
        .I_AVS_WRITEDATA    (wdata),
        .I_AVS_BYTEENABLE   (ben),
        .O_AVS_READDATA     (rdata),
        .O_AVS_WAITREQUEST  (waitreq),
        .O_COMPARE_OUTPUT_A (pin_a),
        .O_COMPARE_OUTPUT_B (pin_b),
        .O_OVERFLOW_FLAG    (ovf),
        .O_COUNTER_VALUE    (cnt)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // pins start unknown in a mode until their first event
    task automatic pin_step(input logic [1:0] act, input logic [7:0] cv,
                            inout logic p, inout bit k);
        if (act < 2'h2) begin
            p = 1'b0;
            k = 1;
        end else if (m_cnt == cv) begin
            p = (act == ACT_SET_UP) ? m_up : ~m_up;
            k = 1;
        end
    endtask

    task automatic mstep();
        logic [7:0] top;
        logic       pwm;
        m_set = 1'b0;
        pwm = (m_ctrl[2:0] == WGM_PC_FIXED) || (m_ctrl[2:0] == WGM_PC_CMPA);
        // TOP follows the active copy, which reloads at TOP and on every step while pwm is off
        top = (m_ctrl[2:0] == WGM_PC_CMPA) ? m_aa : 8'hFF;
        if (!pwm) begin
            m_up = 1'b1;
            m_aa = m_ca;
            m_ab = m_cb;
            m_ka = 0;
            m_kb = 0;
        end else begin
            pin_step(m_ctrl[5:4], m_aa, m_pa, m_ka);
            pin_step(m_ctrl[7:6], m_ab, m_pb, m_kb);
            if (m_cnt == 8'h00) begin
                m_ovf = 1'b1;
                m_set = 1'b1;
            end
            if (m_up && m_cnt >= top) begin
                m_up = 1'b0;
                if (m_cnt != 8'h00) m_cnt--;
                m_aa = m_ca;
                m_ab = m_cb;
            end else if (m_up || m_cnt == 8'h00) begin
                m_up = 1'b1;
                if (top != 8'h00) m_cnt++;
            end else begin
                m_cnt--;
            end
        end
    endtask

    // values read here are those from just before the edge
    task automatic tick_edge();
        @(posedge clk);
        if (rst_n) begin
            mstep();
        end
    endtask

    task automatic run(input int n);
        repeat (n) tick_edge();
    endtask

    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        ben <= be;
        rd <= ~w;
        wr <= w;
        do begin
            tick_edge();
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        if (n >= 50) begin
            err_count++;
            test_done();
        end
        if (w && be[0]) begin
            case (a)
                `PWM_REG_CTRL:   m_ctrl = d[7:0];
                `PWM_REG_CMP_A:  m_ca = d[7:0];
                `PWM_REG_CMP_B:  m_cb = d[7:0];
                `PWM_REG_COUNT:  m_cnt = d[7:0];
                `PWM_REG_STATUS: m_ovf = m_ovf & (m_set | ~d[0]);
                default:         ;
            endcase
        end
        rd <= 1'b0;
        wr <= 1'b0;
        tick_edge();
    endtask

    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, 4'hF, q);
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q, e);
    endtask

    always @(posedge clk) begin
        #1;
        if (m_on) begin
            chk(cnt, m_cnt);
            chk(ovf, m_ovf);
            if (m_ka) chk(pin_a, m_pa);
            if (m_kb) chk(pin_b, m_pb);
        end
    end

    initial begin
        logic [7:0]  cfg [4];
        logic [7:0]  top;
        logic [2:0]  md;
        logic [31:0] q;
        logic [7:0]  c0;
        int          n;
        cfg = '{8'hE1, 8'hD5, 8'h85, 8'hB1};
        {rst_n, rd, wr, addr, wdata, ben} = '0;
        {err_count, n_checks, m_on} = '0;
        {m_ctrl, m_ca, m_cb, m_aa, m_ab, m_cnt} = '0;
        {m_ovf, m_set, m_pa, m_pb} = '0;
        m_up = 1'b1;
        void'($urandom(32'h28BFC6AA));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        tick_edge();
        for (int i = 0; i < 5; i++) begin
            rchk(5'(i * 4), 32'h0);
        end
        rchk(5'h18, 32'h0);
        wreg(5'h18, 8'h5A);
        rchk(5'h18, 32'h0);
        m_on = 1;
        foreach (cfg[i]) begin
            md = 3'($urandom_range(0, 7));
            if (md == WGM_PC_FIXED || md == WGM_PC_CMPA) md = md ^ 3'h2;
            wreg(`PWM_REG_CTRL, {5'h0, md});
            top = 8'($urandom_range(8, 254));
            wreg(`PWM_REG_CMP_A, top);
            if (cfg[i][2:0] == WGM_PC_FIXED) top = 8'hFF;
            wreg(`PWM_REG_CMP_B, 8'($urandom_range(1, top - 1)));
            wreg(`PWM_REG_COUNT, 8'($urandom_range(0, top - 1)));
            rchk(`PWM_REG_COUNT, {24'h0, m_cnt});
            run(3);
            rchk(`PWM_REG_STATUS, {30'h0, 1'b1, m_ovf});
            // low byte disabled: the mode must not change
            bus(1'b1, `PWM_REG_CTRL, {24'h0, cfg[i]}, 4'hE, q);
            rchk(`PWM_REG_CTRL, {29'h0, md});
            wreg(`PWM_REG_CTRL, cfg[i]);
            run(2 * int'(top) + 40);
            // direction bit must follow the count direction, up or down
            rchk(`PWM_REG_STATUS, {30'h0, m_up, m_ovf});
            wreg(`PWM_REG_STATUS, 8'h01);
            run(2 * int'(top) + 40);
        end
        // a divider of four must space counter steps four clocks apart
        wreg(`PWM_REG_CTRL, 8'h00);
        m_on = 0;
        wreg(`PWM_REG_PRESC, 8'h03);
        wreg(`PWM_REG_CTRL, 8'h01);
        c0 = cnt;
        n = 0;
        while (cnt === c0 && n < 20) begin
            tick_edge();
            n++;
        end
        if (n >= 20) begin
            err_count++;
            test_done();
        end
        c0 = cnt;
        n = 0;
        do begin
            tick_edge();
            n++;
        end while (cnt === c0 && n < 20);
        chk(n, 4);
        test_done();
    end
endmodule

`default_nettype wire
